// >>> bench/hpgic_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hpgic_host_model (
    input wire logic clk_i,
    output logic address_strobe_pin_o
);
    initial address_strobe_pin_o = 1'h0;
    // Host moves the strobe level mid-cycle, then holds it a number of cycles
    task automatic drive(input logic lvl, input int hold);
        @(posedge clk_i);
        #37 address_strobe_pin_o = lvl; // Always 37 ns after the rising clk edge
        repeat (hold) @(posedge clk_i);
    endtask : drive
endmodule : hpgic_host_model
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "hpgic_params.svh"
module testbench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic emu = 1'h0;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, pin, sh, sg, ev, ci, halt, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails = 0;
    int tests_run = 0;
    // Clock of 100 ns period
    always #50 clk = ~clk;
    hpgic_top hpgic_top_i (.clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .address_strobe_pin_i(pin), .emu_suspend_i(emu),
        .strobe_host_o(sh), .strobe_gpio_o(sg), .dma_event12_o(ev),
        .cpu_interrupt_six_o(ci), .periph_halt_o(halt), .irq_o(irq));
    hpgic_host_model hpgic_host_model_i (.clk_i(clk), .address_strobe_pin_o(pin));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] val);
        tests_run++;
        if (val !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, val);
        end
    endtask : chk
    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // Bus write, address and data offered together
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid && bready)
                break;
        end
        bready <= 1'h0;
        if (n == 50) begin
            fails++;
            final_report();
        end
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
    endtask : wr
    // Bus read with expected data and response
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid && rready)
                break;
        end
        rready <= 1'h0;
        if (n == 50) begin
            fails++;
            final_report();
        end
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
        chk($sformatf("rdata %h", a), exp, rdata);
    endtask : rd
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        rd(`HPG_ADDR_SUSP, 32'h0, 2'h0);
        rd(`HPG_ADDR_INTC, 32'h0, 2'h0);
        rd(`HPG_ADDR_PFEN, 32'h0, 2'h0);
        wr(`HPG_ADDR_SUSP, 32'hFFFFFFFD, 2'h0);
        rd(`HPG_ADDR_SUSP, 32'h00000001, 2'h0);
        wr(`HPG_ADDR_SUSP, 32'h0, 2'h0);
        wr(`HPG_ADDR_INTC, 32'hFFFCFFFC, 2'h0);
        rd(`HPG_ADDR_INTC, 32'h00040004, 2'h0);
        wr(`HPG_ADDR_PFEN, 32'hFFFFFFFF, 2'h0);
        rd(`HPG_ADDR_PFEN, 32'h0001FFFF, 2'h0);
        wr(32'h43000010, 32'h5, 2'h2);
        rd(32'h43000010, 32'h0, 2'h2);
        // Enable, polarity and pin level, unsupported bits kept at zero
        for (int k = 0; k < 8; k++) begin
            wr(`HPG_ADDR_INTC, {13'h0, k[1], 2'h0, 13'h0, k[0], 2'h0}, 2'h0);
            hpgic_host_model_i.drive(k[2], 8);
            chk("dma_event12", {31'h0, k[0] & (k[2] ^ k[1])}, {31'h0, ev});
            chk("cpu_interrupt_six", {31'h0, k[0] & (k[2] ^ k[1])}, {31'h0, ci});
        end
        wr(`HPG_ADDR_INTC, 32'h00000004, 2'h0);
        hpgic_host_model_i.drive(1'h0, 8);
        // Strobe passes the synchroniser before reaching the event
        hpgic_host_model_i.drive(1'h1, 2);
        chk("event early", 32'h0, {31'h0, ev});
        repeat (6) @(posedge clk);
        chk("event late", 32'h1, {31'h0, ev});
        // Pin group selects host or general-purpose use of the strobe
        wr(`HPG_ADDR_PFEN, 32'h0, 2'h0);
        repeat (6) @(posedge clk);
        chk("host strobe", 32'h1, {31'h0, sh});
        chk("gpio strobe", 32'h0, {31'h0, sg});
        wr(`HPG_ADDR_PFEN, 32'h00000004, 2'h0);
        repeat (6) @(posedge clk);
        chk("host strobe", 32'h0, {31'h0, sh});
        chk("gpio strobe", 32'h1, {31'h0, sg});
        // Byte strobes write only the selected lane
        wstrb <= 4'h2;
        wr(`HPG_ADDR_PFEN, 32'hFFFFFFFF, 2'h0);
        wstrb <= 4'hF;
        rd(`HPG_ADDR_PFEN, 32'h0000FF04, 2'h0);
        // Suspend reaction with free-run off and on, soft-stop kept at zero
        emu <= 1'h1;
        for (int s = 0; s < 2; s++) begin
            wr(`HPG_ADDR_SUSP, s, 2'h0);
            repeat (3) @(posedge clk);
            chk("halt", 32'h0, {31'h0, halt});
            chk("event in suspend", 32'h1, {31'h0, ev});
        end
        wr(`HPG_ADDR_SUSP, 32'h0, 2'h0);
        emu <= 1'h0;
        // Sticky status, mask and clear by writing one
        hpgic_host_model_i.drive(1'h0, 8);
        wr(`HPG_ADDR_STAT, 32'h1, 2'h0);
        rd(`HPG_ADDR_STAT, 32'h0, 2'h0);
        hpgic_host_model_i.drive(1'h1, 8);
        rd(`HPG_ADDR_STAT, 32'h1, 2'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`HPG_ADDR_MASK, 32'h1, 2'h0);
        rd(`HPG_ADDR_MASK, 32'h1, 2'h0);
        repeat (3) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(`HPG_ADDR_STAT, 32'h1, 2'h0);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(`HPG_ADDR_STAT, 32'h0, 2'h0);
        final_report();
    end
endmodule : testbench
`default_nettype wire

// >>> hw/hpgic_params.svh
// Overview of operation
// - With the suspend-behaviour bit at 0 the block keeps running under emulation suspend.
// - With the free-run bit at 0 the suspend-behaviour bit decides the suspend reaction.
// - With the free-run bit at 1 the block runs on under suspend whatever the other bit is.
// - Polarity bit 18 at 0 drives DMA event 12 and CPU interrupt 6 from the strobe as is.
// - Polarity bit 18 at 1 drives DMA event 12 and CPU interrupt 6 from the inverted strobe.
// - Enable bit 2 at 0 suppresses every event and interrupt from the strobe pin.
// - Enable bit 2 at 1 passes the polarity-adjusted strobe to DMA event 12 and interrupt 6.
// - Pin-group enable bits 16 to 0 are read/write; bits 31 to 17 are reserved, read-only.
// - Pin-group enable bit 2 at 1 turns the strobe pin into a general-purpose pin.
// - No real suspend mechanism is needed; suspend bits are stored and read back.
`ifndef HPGIC_PARAMS_SVH
`define HPGIC_PARAMS_SVH
// Register byte addresses
`define HPG_ADDR_SUSP 32'h43000004
`define HPG_ADDR_INTC 32'h43000008
`define HPG_ADDR_PFEN 32'h4300000C
`define HPG_ADDR_STAT 32'h43000020
`define HPG_ADDR_MASK 32'h43000024
// Writable bit masks
`define HPG_MASK_SUSP 32'h00000003
`define HPG_MASK_INTC 32'h00070007
`define HPG_MASK_PFEN 32'h0001FFFF
`define HPG_MASK_EVT 32'h00000001
// Field positions
`define HPG_BIT_FREE 0
`define HPG_BIT_SOFT 1
`define HPG_BIT_EN 2
`define HPG_BIT_POL 18
`define HPG_BIT_PFEN_STB 2
`define HPG_BIT_EVT 0
// Reset value
`define HPG_RST_VAL 32'h00000000
// Responses
`define HPG_RESP_OKAY 2'h0
`define HPG_RESP_SLVERR 2'h2
`endif

// >>> hw/hpgic_pkg.sv
package hpgic_pkg;
    // Write channel states
    typedef enum logic [1:0] {
        HPGIC_WS_IDLE = 2'h1,
        HPGIC_WS_RESP = 2'h2
    } hpgic_wstate_t;
endpackage : hpgic_pkg

// >>> hw/hpgic_top.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "hpgic_params.svh"
module hpgic_top
    import hpgic_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic address_strobe_pin_i,
    input wire logic emu_suspend_i,
    output logic strobe_host_o,
    output logic strobe_gpio_o,
    output logic dma_event12_o,
    output logic cpu_interrupt_six_o,
    output logic periph_halt_o,
    output logic irq_o
);
    // Elaboration check on address width
    generate
        if (ADDR_W != 32) begin : g_bad_addr
            $error("ADDR_W must be 32");
        end
    endgenerate

    hpgic_wstate_t wstate_q;
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] bmask;
    logic do_wr;
    logic [31:0] susp_q;
    logic [31:0] intc_q;
    logic [31:0] pfen_q;
    logic [31:0] stat_q;
    logic [31:0] mask_q;
    logic [31:0] rd_val;
    logic rd_ok;
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic filt_q;
    logic evt_d;
    logic evt_rise;
    logic [31:0] wr_val;

    // Byte strobes widened to a bit mask
    generate
        for (genvar b = 0; b < 4; b++) begin : g_bmask
            assign bmask[b*8 +: 8] = {8{wstrb_q[b]}};
        end
    endgenerate

    assign do_wr = (wstate_q == HPGIC_WS_IDLE) && aw_have_q && w_have_q;
    assign wr_val = wdata_q & bmask;

    // Write address capture
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_have_q <= 1'b0;
            waddr_q <= '0;
            s_axi_awready_o <= 1'b0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            waddr_q <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
        end else if (do_wr) begin
            aw_have_q <= 1'b0;
        end else if (wstate_q == HPGIC_WS_IDLE && !aw_have_q) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_wready_o <= 1'b0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
        end else if (do_wr) begin
            w_have_q <= 1'b0;
        end else if (wstate_q == HPGIC_WS_IDLE && !w_have_q) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wstate_q <= HPGIC_WS_IDLE;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `HPG_RESP_OKAY;
        end else begin
            case (wstate_q)
                HPGIC_WS_IDLE: begin
                    if (do_wr) begin
                        wstate_q <= HPGIC_WS_RESP;
                        s_axi_bvalid_o <= 1'b1;
                        if (waddr_q == `HPG_ADDR_SUSP || waddr_q == `HPG_ADDR_INTC ||
                            waddr_q == `HPG_ADDR_PFEN || waddr_q == `HPG_ADDR_STAT ||
                            waddr_q == `HPG_ADDR_MASK) begin
                            s_axi_bresp_o <= `HPG_RESP_OKAY;
                        end else begin
                            s_axi_bresp_o <= `HPG_RESP_SLVERR;
                        end
                    end
                end
                HPGIC_WS_RESP: begin
                    if (s_axi_bready_i) begin
                        wstate_q <= HPGIC_WS_IDLE;
                        s_axi_bvalid_o <= 1'b0;
                    end
                end
                default: begin
                    wstate_q <= HPGIC_WS_IDLE;
                    s_axi_bvalid_o <= 1'b0;
                end
            endcase
        end
    end

    // Control registers, reserved bits held at zero
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            susp_q <= `HPG_RST_VAL;
            intc_q <= `HPG_RST_VAL;
            pfen_q <= `HPG_RST_VAL;
            mask_q <= `HPG_RST_VAL;
        end else if (do_wr) begin
            if (waddr_q == `HPG_ADDR_SUSP) begin
                susp_q <= ((susp_q & ~bmask) | wr_val) & `HPG_MASK_SUSP;
            end else if (waddr_q == `HPG_ADDR_INTC) begin
                intc_q <= ((intc_q & ~bmask) | wr_val) & `HPG_MASK_INTC;
            end else if (waddr_q == `HPG_ADDR_PFEN) begin
                pfen_q <= ((pfen_q & ~bmask) | wr_val) & `HPG_MASK_PFEN;
            end else if (waddr_q == `HPG_ADDR_MASK) begin
                mask_q <= ((mask_q & ~bmask) | wr_val) & `HPG_MASK_EVT;
            end
        end
    end

    // Read decode
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        if (s_axi_araddr_i == `HPG_ADDR_SUSP) begin
            rd_val = susp_q;
        end else if (s_axi_araddr_i == `HPG_ADDR_INTC) begin
            rd_val = intc_q;
        end else if (s_axi_araddr_i == `HPG_ADDR_PFEN) begin
            rd_val = pfen_q;
        end else if (s_axi_araddr_i == `HPG_ADDR_STAT) begin
            rd_val = stat_q;
        end else if (s_axi_araddr_i == `HPG_ADDR_MASK) begin
            rd_val = mask_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= `HPG_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_val;
            s_axi_rresp_o <= rd_ok ? `HPG_RESP_OKAY : `HPG_RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end else if (!s_axi_rvalid_o) begin
            s_axi_arready_o <= 1'b1;
        end
    end

    // Strobe pin synchroniser and agreement filter
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            filt_q <= 1'b0;
        end else begin
            sync1_q <= address_strobe_pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                filt_q <= sync3_q;
            end
        end
    end

    // Polarity then enable gating
    assign evt_d = intc_q[`HPG_BIT_EN] & (filt_q ^ intc_q[`HPG_BIT_POL]);
    assign evt_rise = evt_d & ~dma_event12_o;

    // Event outputs and pin function steering
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dma_event12_o <= 1'b0;
            cpu_interrupt_six_o <= 1'b0;
            strobe_host_o <= 1'b0;
            strobe_gpio_o <= 1'b0;
        end else begin
            dma_event12_o <= evt_d;
            cpu_interrupt_six_o <= evt_d;
            strobe_host_o <= filt_q & ~pfen_q[`HPG_BIT_PFEN_STB];
            strobe_gpio_o <= filt_q & pfen_q[`HPG_BIT_PFEN_STB];
        end
    end

    // Sticky status, set wins over write-one-clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stat_q <= `HPG_RST_VAL;
        end else if (evt_rise) begin
            stat_q[`HPG_BIT_EVT] <= 1'b1;
        end else if (do_wr && waddr_q == `HPG_ADDR_STAT) begin
            stat_q <= stat_q & ~wr_val;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_q & mask_q);
        end
    end

    // Suspend reaction, halts only in the unsupported soft-stop setting
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            periph_halt_o <= 1'b0;
        end else begin
            periph_halt_o <= emu_suspend_i & ~susp_q[`HPG_BIT_FREE] &
                susp_q[`HPG_BIT_SOFT];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Gating, polarity, filter, suspend, pin-function, reserved-bit and status checks
    a_evt_gated_off: assert property (!$past(intc_q[`HPG_BIT_EN]) |-> !dma_event12_o)
        else $error("event while strobe enable off");
    a_evt_pol_zero: assert property (intc_q[`HPG_BIT_EN] && !intc_q[`HPG_BIT_POL]
        |=> dma_event12_o == $past(filt_q))
        else $error("event not equal to strobe");
    a_evt_pol_one: assert property (intc_q[`HPG_BIT_EN] && intc_q[`HPG_BIT_POL]
        |=> dma_event12_o == !$past(filt_q))
        else $error("event not inverted strobe");
    a_int_six_match: assert property (intc_q[`HPG_BIT_EN]
        |=> cpu_interrupt_six_o == ($past(filt_q) ^ $past(intc_q[`HPG_BIT_POL])))
        else $error("interrupt six differs from strobe");
    a_sync_pin_high: assert property (address_strobe_pin_i [*5] |=> filt_q)
        else $error("stable pin not seen by filter");
    a_halt_free_run: assert property (susp_q[`HPG_BIT_FREE] |=> !periph_halt_o)
        else $error("halt with free run set");
    a_halt_soft_zero: assert property (!susp_q[`HPG_BIT_SOFT] |=> !periph_halt_o)
        else $error("halt with soft bit clear");
    a_host_strobe_gpio: assert property (pfen_q[`HPG_BIT_PFEN_STB] |=> !strobe_host_o)
        else $error("host strobe active in gpio mode");
    a_resv_read_zero: assert property ($rose(s_axi_rvalid_o) &&
        $past(s_axi_araddr_i) == `HPG_ADDR_PFEN |-> s_axi_rdata_o[31:17] == 15'h0000)
        else $error("reserved enable bits read nonzero");
    a_stat_sticky: assert property ($rose(dma_event12_o) |=> ##[0:2] stat_q[`HPG_BIT_EVT])
        else $error("event not latched in status");

    c_evt_raised: cover property ($rose(dma_event12_o));
    c_irq_raised: cover property ($rose(irq_o));
    c_write_done: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_read_done: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule : hpgic_top
`default_nettype wire
